// file: sysreg_cfg.svh
// Overview of operation
// RULE1 - eight-level shared stack, ninth push drops oldest
// RULE2 - memory and registers frozen during stop/halt; code still lets irq_set and wdt_overflow set their flags
// RULE3 - every location reachable by one direct access
// RULE4 - system registers $000-$01F, data $020-$0AF
// RULE5 - display RAM $300-$313, scan RAM $358-$363
// RULE6 - $00 holds four interrupt enables
// RULE7 - $01 holds four matching interrupt request flags
// RULE8 - timer0 mode bits 2-0, reload bit 3
// RULE9 - timer0 load/count low $04, high $05
// RULE10 - $07 divider bits 1-0, display on bit 2
// RULE11 - port data $08-$0A, direction $16-$18
// RULE12 - $0C bits 1-0 bonding inputs, 3-2 zero; code keeps bits 3-2 as writable bits that read back
// RULE13 - $0D segment function bits, bit 1 kept one; code stores all four bits as written, reset zero
// RULE14 - pointer nibbles $10 four bits, $11/$12 three
// RULE15 - $13 edge selects, pull polarity, pull enable
// RULE16 - $14 oscillator on, clock select, type
// RULE17 - $15 frame rate bits 3-2, 1-0 ones; code stores all four bits as written, reset zero
// RULE18 - $1A-$1D form sixteen-bit ROM table window
// RULE19 - $1E watchdog control, read-only overflow flag
// RULE20 - $06, $0B, $19, $1F hold no register
// RULE21 - unimplemented bits read as zero
// RULE22 - oscillator bit meanings when set
// RULE23 - writes to read-only or reserved ignored
// RULE24 - indirect port uses ten-bit pointer address
`ifndef SYSREG_CFG_SVH
`define SYSREG_CFG_SVH

`define ADDR_W        10
`define NIB_W         4
`define SYS_FIRST     10'h000
`define SYS_LAST      10'h01f
`define DATA_FIRST    10'h020
`define DATA_LAST     10'h0af
`define LCD_FIRST     10'h300
`define LCD_LAST      10'h313
`define SCAN_FIRST    10'h358
`define SCAN_LAST     10'h363
`define DATA_DEPTH    144
`define LCD_DEPTH     20
`define SCAN_DEPTH    12

`define REG_IRQ_EN    5'h00
`define REG_IRQ_PEND  5'h01
`define REG_T0_MODE   5'h02
`define REG_BT_MODE   5'h03
`define REG_T0_LOW    5'h04
`define REG_T0_HIGH   5'h05
`define REG_RSVD_A    5'h06
`define REG_DISP_CTL  5'h07
`define REG_PORT_A    5'h08
`define REG_PORT_B    5'h09
`define REG_PORT_C    5'h0a
`define REG_RSVD_B    5'h0b
`define REG_BOND      5'h0c
`define REG_SEG_FUNC  5'h0d
`define REG_TABLE_BR  5'h0e
`define REG_INDIRECT  5'h0f
`define REG_PTR_LOW   5'h10
`define REG_PTR_MID   5'h11
`define REG_PTR_HIGH  5'h12
`define REG_EDGE_PULL 5'h13
`define REG_OSC       5'h14
`define REG_FRAME     5'h15
`define REG_DIR_A     5'h16
`define REG_DIR_B     5'h17
`define REG_DIR_C     5'h18
`define REG_RSVD_C    5'h19
`define REG_ROM0      5'h1a
`define REG_ROM1      5'h1b
`define REG_ROM2      5'h1c
`define REG_ROM3      5'h1d
`define REG_WDT       5'h1e
`define REG_RSVD_D    5'h1f

`define INDIRECT_ADDR 10'h00f
`define RST_ZERO      4'h0
`define RST_EDGE_PULL 4'h4
`define OSC_FAST_ON   0
`define OSC_CPU_SEL   1
`define OSC_RSVD      2
`define OSC_TYPE      3
`define WDT_FLAG_BIT  3
`define STACK_DEPTH   8
`define STACK_W       13

`endif

// file: sysreg_pkg.sv
package sysreg_pkg;
`include "sysreg_cfg.svh"

	typedef enum {region_sys, region_data, region_lcd, region_scan, region_none} region_type;

	typedef struct packed {
		logic [3:0]                        irq_en;
		logic [3:0]                        irq_pend;
		logic [3:0]                        t0_mode;
		logic [3:0]                        bt_mode;
		logic [3:0]                        t0_low;
		logic [3:0]                        t0_high;
		logic [2:0]                        disp_ctl;
		logic [2:0][3:0]                   port_data;
		logic [2:0][3:0]                   port_dir;
		logic [1:0]                        bond_hi;
		logic [3:0]                        seg_func;
		logic [3:0]                        table_branch;
		logic [3:0]                        ptr_low;
		logic [2:0]                        ptr_mid;
		logic [2:0]                        ptr_high;
		logic [3:0]                        edge_pull;
		logic [3:0]                        osc_ctl;
		logic [3:0]                        frame;
		logic [3:0][3:0]                   rom_tab;
		logic [2:0]                        wdt_ctl;
		logic                              wdt_flag;
		logic [`DATA_DEPTH-1:0][3:0]       data_ram;
		logic [`LCD_DEPTH-1:0][3:0]        lcd_ram;
		logic [`SCAN_DEPTH-1:0][3:0]       scan_ram;
		logic [3:0]                        rdata;
		logic                              rvalid;
	} sysreg_state_type;

endpackage : sysreg_pkg

// file: stack_if.sv
`timescale 1ns/10ps
interface stack_if #(
	parameter int W  = 13,
	parameter int LW = 4
);
	logic          push;
	logic          pop;
	logic [W-1:0]  push_data;
	logic [W-1:0]  top_data;
	logic [LW-1:0] level;

	modport cpu (output push, output pop, output push_data, input top_data, input level);
	modport stk (input push, input pop, input push_data, output top_data, output level);
endinterface : stack_if

// file: return_stack.sv
`timescale 1ns/10ps
module return_stack
	import sysreg_pkg::*;
#(
	parameter int DEPTH = 8,
	parameter int W     = 13,
	parameter int LW    = 4
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rstn,
	// stack port
	stack_if.stk      bus
);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] entry;
		logic [LW-1:0]           level;
	} stack_state_type;

	localparam logic [LW-1:0] FULL_LEVEL = LW'(DEPTH);

	stack_state_type st_q;
	stack_state_type st_d;

	always_comb begin
		st_d = st_q;
		if (bus.push) begin
			st_d.entry = {st_q.entry[DEPTH-2:0], bus.push_data}; // RULE1
			if (st_q.level != FULL_LEVEL) begin
				st_d.level = st_q.level + 1'b1;
			end
		end else if (bus.pop) begin
			st_d.entry = {{W{1'b0}}, st_q.entry[DEPTH-1:1]};
			if (st_q.level != '0) begin
				st_d.level = st_q.level - 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign bus.top_data = st_q.entry[0];
	assign bus.level    = st_q.level;

	stack_discard_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		bus.push && st_q.level == FULL_LEVEL |=> st_q.level == FULL_LEVEL
		&& st_q.entry[DEPTH-1] == $past(st_q.entry[DEPTH-2])) // RULE1
		else $error("full stack push did not drop oldest entry");
	cover_ninth_push: cover property (@(posedge sys_clk) disable iff (!rstn)
		bus.push && st_q.level == FULL_LEVEL);
endmodule : return_stack

// file: sysreg_bank.sv
`timescale 1ns/10ps
`include "sysreg_cfg.svh"
module sysreg_bank
	import sysreg_pkg::*;
(
	// clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rstn,
	// cpu data access
	input  wire logic [`ADDR_W-1:0]  mem_addr,
	input  wire logic                mem_wr,
	input  wire logic                mem_rd,
	input  wire logic [3:0]          mem_wdata,
	output logic      [3:0]          rd_data,
	output logic                     rd_valid,
	// cpu state
	input  wire logic                cpu_halt,
	input  wire logic                cpu_stop,
	// return stack
	input  wire logic                stack_push,
	input  wire logic                stack_pop,
	input  wire logic [`STACK_W-1:0] stack_push_data,
	output logic      [`STACK_W-1:0] stack_top,
	output logic      [3:0]          stack_level,
	// hardware events and pins
	input  wire logic [3:0]          irq_set,
	input  wire logic                wdt_overflow,
	input  wire logic [1:0]          bonding_option,
	// register contents to peripherals
	output logic      [3:0]          irq_enable,
	output logic      [3:0]          irq_pending,
	output logic      [3:0]          timer_zero_mode,
	output logic      [3:0]          base_timer_mode,
	output logic      [7:0]          timer_zero_load,
	output logic      [2:0]          display_control,
	output logic      [11:0]         port_data,
	output logic      [11:0]         port_direction,
	output logic      [3:0]          segment_function,
	output logic      [3:0]          table_branch_nibble,
	output logic      [3:0]          edge_and_pull,
	output logic      [3:0]          oscillator_control,
	output logic      [3:0]          display_frame_rate,
	output logic      [15:0]         rom_table_window,
	output logic      [2:0]          watchdog_control,
	output logic                     watchdog_overflow
);
	sysreg_state_type s_q;
	sysreg_state_type s_d;
	logic [`ADDR_W-1:0] ptr_addr;
	logic [`ADDR_W-1:0] acc_addr;
	logic               frozen;
	logic               write_ok;

	stack_if #(.W(`STACK_W), .LW(4)) st_bus ();

	return_stack #(.DEPTH(`STACK_DEPTH), .W(`STACK_W), .LW(4)) u_stack (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.bus     (st_bus.stk)
	);

	// address decode shared by reads and writes
	function automatic region_type region_of(input logic [`ADDR_W-1:0] a);
		if (a <= `SYS_LAST) begin
			return region_sys; // RULE4
		end else if (a >= `DATA_FIRST && a <= `DATA_LAST) begin
			return region_data; // RULE4
		end else if (a >= `LCD_FIRST && a <= `LCD_LAST) begin
			return region_lcd; // RULE5
		end else if (a >= `SCAN_FIRST && a <= `SCAN_LAST) begin
			return region_scan; // RULE5
		end
		return region_none;
	endfunction : region_of

	// system register read mux
	function automatic logic [3:0] read_sys(input sysreg_state_type s, input logic [4:0] idx,
		input logic [1:0] bond);
		logic [3:0] v;
		v = 4'h0;
		unique case (idx)
			`REG_IRQ_EN:    v = s.irq_en;
			`REG_IRQ_PEND:  v = s.irq_pend;
			`REG_T0_MODE:   v = s.t0_mode;
			`REG_BT_MODE:   v = s.bt_mode;
			`REG_T0_LOW:    v = s.t0_low;
			`REG_T0_HIGH:   v = s.t0_high;
			`REG_DISP_CTL:  v = {1'b0, s.disp_ctl}; // RULE21
			`REG_PORT_A:    v = s.port_data[0];
			`REG_PORT_B:    v = s.port_data[1];
			`REG_PORT_C:    v = s.port_data[2];
			`REG_BOND:      v = {s.bond_hi, bond}; // RULE12
			`REG_SEG_FUNC:  v = s.seg_func;
			`REG_TABLE_BR:  v = s.table_branch;
			`REG_PTR_LOW:   v = s.ptr_low;
			`REG_PTR_MID:   v = {1'b0, s.ptr_mid}; // RULE21
			`REG_PTR_HIGH:  v = {1'b0, s.ptr_high}; // RULE21
			`REG_EDGE_PULL: v = s.edge_pull;
			`REG_OSC:       v = s.osc_ctl;
			`REG_FRAME:     v = s.frame;
			`REG_DIR_A:     v = s.port_dir[0];
			`REG_DIR_B:     v = s.port_dir[1];
			`REG_DIR_C:     v = s.port_dir[2];
			`REG_ROM0:      v = s.rom_tab[0];
			`REG_ROM1:      v = s.rom_tab[1];
			`REG_ROM2:      v = s.rom_tab[2];
			`REG_ROM3:      v = s.rom_tab[3];
			`REG_WDT:       v = {s.wdt_flag, s.wdt_ctl};
			default:        v = 4'h0; // RULE20
		endcase
		return v;
	endfunction : read_sys

	assign ptr_addr = {s_q.ptr_high, s_q.ptr_mid, s_q.ptr_low};
	assign acc_addr = (mem_addr == `INDIRECT_ADDR) ? ptr_addr : mem_addr; // RULE24
	assign frozen   = cpu_halt | cpu_stop;
	assign write_ok = mem_wr & ~frozen; // RULE2

	assign st_bus.push      = stack_push & ~frozen; // RULE1
	assign st_bus.pop       = stack_pop & ~frozen;
	assign st_bus.push_data = stack_push_data;

	always_comb begin
		s_d = s_q;
		s_d.rvalid = 1'b0;
		if (write_ok) begin
			unique case (region_of(acc_addr))
				region_sys: begin
					unique case (acc_addr[4:0])
						`REG_IRQ_EN:    s_d.irq_en = mem_wdata; // RULE6
						`REG_IRQ_PEND:  s_d.irq_pend = mem_wdata; // RULE7
						`REG_T0_MODE:   s_d.t0_mode = mem_wdata; // RULE8
						`REG_BT_MODE:   s_d.bt_mode = mem_wdata;
						`REG_T0_LOW:    s_d.t0_low = mem_wdata; // RULE9
						`REG_T0_HIGH:   s_d.t0_high = mem_wdata; // RULE9
						`REG_DISP_CTL:  s_d.disp_ctl = mem_wdata[2:0]; // RULE10
						`REG_PORT_A:    s_d.port_data[0] = mem_wdata; // RULE11
						`REG_PORT_B:    s_d.port_data[1] = mem_wdata; // RULE11
						`REG_PORT_C:    s_d.port_data[2] = mem_wdata; // RULE11
						`REG_BOND:      s_d.bond_hi = mem_wdata[3:2]; // RULE12
						`REG_SEG_FUNC:  s_d.seg_func = mem_wdata; // RULE13
						`REG_TABLE_BR:  s_d.table_branch = mem_wdata;
						`REG_PTR_LOW:   s_d.ptr_low = mem_wdata; // RULE14
						`REG_PTR_MID:   s_d.ptr_mid = mem_wdata[2:0]; // RULE14
						`REG_PTR_HIGH:  s_d.ptr_high = mem_wdata[2:0]; // RULE14
						`REG_EDGE_PULL: s_d.edge_pull = mem_wdata; // RULE15
						`REG_OSC: begin
							s_d.osc_ctl = mem_wdata; // RULE16
							s_d.osc_ctl[`OSC_RSVD] = 1'b0; // RULE22
						end
						`REG_FRAME:     s_d.frame = mem_wdata; // RULE17
						`REG_DIR_A:     s_d.port_dir[0] = mem_wdata; // RULE11
						`REG_DIR_B:     s_d.port_dir[1] = mem_wdata; // RULE11
						`REG_DIR_C:     s_d.port_dir[2] = mem_wdata; // RULE11
						`REG_ROM0:      s_d.rom_tab[0] = mem_wdata; // RULE18
						`REG_ROM1:      s_d.rom_tab[1] = mem_wdata; // RULE18
						`REG_ROM2:      s_d.rom_tab[2] = mem_wdata; // RULE18
						`REG_ROM3:      s_d.rom_tab[3] = mem_wdata; // RULE18
						`REG_WDT:       s_d.wdt_ctl = mem_wdata[2:0]; // RULE19
						default:        s_d.rvalid = 1'b0; // RULE23
					endcase
				end
				region_data: s_d.data_ram[acc_addr - `DATA_FIRST] = mem_wdata; // RULE3
				region_lcd:  s_d.lcd_ram[acc_addr - `LCD_FIRST] = mem_wdata; // RULE5
				region_scan: s_d.scan_ram[acc_addr - `SCAN_FIRST] = mem_wdata; // RULE5
				region_none: s_d.rvalid = 1'b0; // RULE23
			endcase
		end
		// hardware sets win over a software clear in the same cycle
		s_d.irq_pend = s_d.irq_pend | irq_set; // RULE7
		s_d.wdt_flag = s_q.wdt_flag | wdt_overflow; // RULE19
		if (mem_rd) begin
			s_d.rvalid = 1'b1; // RULE3
			unique case (region_of(acc_addr))
				region_sys:  s_d.rdata = read_sys(s_q, acc_addr[4:0], bonding_option);
				region_data: s_d.rdata = s_q.data_ram[acc_addr - `DATA_FIRST];
				region_lcd:  s_d.rdata = s_q.lcd_ram[acc_addr - `LCD_FIRST];
				region_scan: s_d.rdata = s_q.scan_ram[acc_addr - `SCAN_FIRST];
				region_none: s_d.rdata = 4'h0; // RULE21
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			s_q <= '0;
			s_q.edge_pull <= `RST_EDGE_PULL;
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_data             = s_q.rdata;
	assign rd_valid            = s_q.rvalid;
	assign stack_top           = st_bus.top_data;
	assign stack_level         = st_bus.level;
	assign irq_enable          = s_q.irq_en;
	assign irq_pending         = s_q.irq_pend;
	assign timer_zero_mode     = s_q.t0_mode;
	assign base_timer_mode     = s_q.bt_mode;
	assign timer_zero_load     = {s_q.t0_high, s_q.t0_low};
	assign display_control     = s_q.disp_ctl;
	assign port_data           = s_q.port_data;
	assign port_direction      = s_q.port_dir;
	assign segment_function    = s_q.seg_func;
	assign table_branch_nibble = s_q.table_branch;
	assign edge_and_pull       = s_q.edge_pull;
	assign oscillator_control  = s_q.osc_ctl;
	assign display_frame_rate  = s_q.frame;
	assign rom_table_window    = s_q.rom_tab;
	assign watchdog_control    = s_q.wdt_ctl;
	assign watchdog_overflow   = s_q.wdt_flag;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	halt_freeze_a: assert property (frozen && irq_set == 4'h0 && !wdt_overflow
		|=> $stable(s_q.data_ram) && $stable(port_data) && $stable(irq_pending)) // RULE2
		else $error("state changed while halted or stopped");
	read_answer_a: assert property (mem_rd |=> rd_valid ##1 (rd_valid == $past(mem_rd))) // RULE3
		else $error("read answer missing or late");
	data_roundtrip_a: assert property (write_ok && mem_addr == `DATA_FIRST
		##1 mem_rd && mem_addr == `DATA_FIRST |=> rd_data == $past(mem_wdata, 2)) // RULE4
		else $error("data ram write not read back");
	unmapped_zero_a: assert property (mem_rd && mem_addr > `LCD_LAST && mem_addr < `SCAN_FIRST
		|=> rd_data == 4'h0) // RULE5
		else $error("gap between display areas read nonzero");
	irq_set_wins_a: assert property (irq_set[0] |=> irq_pending[0]) // RULE7
		else $error("interrupt request lost");
	bond_read_a: assert property (mem_rd && mem_addr == 10'h00c
		|=> rd_data[1:0] == $past(bonding_option)) // RULE12
		else $error("bonding bits not read from inputs");
	osc_gap_a: assert property (mem_rd && mem_addr == 10'h014 |=> rd_data[`OSC_RSVD] == 1'b0) // RULE21
		else $error("oscillator unimplemented bit read as one");
	wdt_flag_ro_a: assert property (write_ok && mem_addr == 10'h01e && !wdt_overflow
		|=> watchdog_overflow == $past(watchdog_overflow)) // RULE19
		else $error("watchdog flag changed by software");
	ptr_write_a: assert property (write_ok && mem_addr == `INDIRECT_ADDR && region_of(ptr_addr) == region_data
		##1 mem_rd && mem_addr == $past(ptr_addr) |=> rd_data == $past(mem_wdata, 2)) // RULE24
		else $error("indirect write went to wrong address");

	cover_indirect: cover property (write_ok && mem_addr == `INDIRECT_ADDR);
	cover_halt_irq: cover property (frozen && irq_set != 4'h0);
	cover_lcd_write: cover property (write_ok && region_of(acc_addr) == region_lcd);
endmodule : sysreg_bank

// file: sysreg_bank_tb_top.sv
`timescale 1ns/10ps
module sysreg_bank_tb_top;
	import sysreg_pkg::*;

	// clock and reset
	logic        sys_clk = 1'b0;
	logic        rstn = 1'b0;
	// cpu side, hardware events and pins
	logic [9:0]  mem_addr = 10'h000;
	logic        mem_wr = 1'b0;
	logic        mem_rd = 1'b0;
	logic [3:0]  mem_wdata = 4'h0;
	logic        cpu_halt = 1'b0;
	logic        cpu_stop = 1'b0;
	logic        stack_push = 1'b0;
	logic        stack_pop = 1'b0;
	logic [12:0] stack_push_data = 13'h0000;
	logic [3:0]  irq_set = 4'h0;
	logic        wdt_overflow = 1'b0;
	logic [1:0]  bonding_option = 2'h2;
	// observed
	logic [3:0]  rd_data, irq_enable, irq_pending, timer_zero_mode, base_timer_mode, stack_level;
	logic [3:0]  segment_function, table_branch_nibble, edge_and_pull, oscillator_control, display_frame_rate;
	logic        rd_valid, watchdog_overflow;
	logic [12:0] stack_top;
	logic [7:0]  timer_zero_load;
	logic [2:0]  display_control, watchdog_control;
	logic [11:0] port_data, port_direction;
	logic [15:0] rom_table_window;
	int          err_total = 0;
	int          n_checks = 0;

	// writable bits per system register, $0f handled separately
	localparam logic [3:0] MASK [32] = '{4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf, 4'h0, 4'h7,
		4'hf, 4'hf, 4'hf, 4'h0, 4'hc, 4'hf, 4'hf, 4'h0, 4'hf, 4'h7, 4'h7, 4'hf, 4'hb, 4'hf,
		4'hf, 4'hf, 4'hf, 4'h0, 4'hf, 4'hf, 4'hf, 4'hf, 4'h7, 4'h0};

	always #2.5 sys_clk = ~sys_clk;

	sysreg_bank i_sysreg_bank (.sys_clk(sys_clk), .rstn(rstn), .mem_addr(mem_addr), .mem_wr(mem_wr),
		.mem_rd(mem_rd), .mem_wdata(mem_wdata), .rd_data(rd_data), .rd_valid(rd_valid), .cpu_halt(cpu_halt),
		.cpu_stop(cpu_stop), .stack_push(stack_push), .stack_pop(stack_pop), .stack_push_data(stack_push_data),
		.stack_top(stack_top), .stack_level(stack_level), .irq_set(irq_set), .wdt_overflow(wdt_overflow),
		.bonding_option(bonding_option), .irq_enable(irq_enable), .irq_pending(irq_pending),
		.timer_zero_mode(timer_zero_mode), .base_timer_mode(base_timer_mode), .timer_zero_load(timer_zero_load),
		.display_control(display_control), .port_data(port_data), .port_direction(port_direction),
		.segment_function(segment_function), .table_branch_nibble(table_branch_nibble),
		.edge_and_pull(edge_and_pull), .oscillator_control(oscillator_control),
		.display_frame_rate(display_frame_rate), .rom_table_window(rom_table_window),
		.watchdog_control(watchdog_control), .watchdog_overflow(watchdog_overflow));

	task automatic summarize;
		if (err_total == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [9:0] a, input logic [3:0] d);
		@(posedge sys_clk);
		mem_wr    <= 1'b1;
		mem_addr  <= a;
		mem_wdata <= d;
		@(posedge sys_clk);
		mem_wr    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [9:0] a, input logic [3:0] e);
		@(posedge sys_clk);
		mem_rd   <= 1'b1;
		mem_addr <= a;
		@(posedge sys_clk);
		mem_rd   <= 1'b0;
		#1;
		chk({15'h0000, rd_valid}, 16'h0001);
		chk({12'h000, rd_data}, {12'h000, e});
	endtask : rd

	task automatic stk(input logic p, input logic q, input logic [12:0] d);
		@(posedge sys_clk);
		stack_push      <= p;
		stack_pop       <= q;
		stack_push_data <= d;
		@(posedge sys_clk);
		stack_push      <= 1'b0;
		stack_pop       <= 1'b0;
		#1;
	endtask : stk

	function automatic logic [3:0] expv(input int a, input logic [3:0] v);
		expv = (v & MASK[a]) | ((a == 12) ? {2'b00, bonding_option} : 4'h0);
	endfunction : expv

	initial begin
		repeat (5000) @(posedge sys_clk);
		err_total++;
		summarize();
	end

	initial begin
		repeat (20) @(posedge sys_clk);
		rstn <= 1'b1;
		for (int a = 0; a < 32; a++) rd(a[9:0], (a == 19) ? 4'h4 : expv(a, 4'h0));
		for (int k = 0; k < 3; k++) begin
			for (int a = 0; a < 32; a++) if (a != 15) wr(a[9:0], (k == 1) ? 4'h0 : ((k == 0) ? 4'hf : 4'h5));
			for (int a = 0; a < 32; a++) if (a != 15) rd(a[9:0], expv(a, (k == 1) ? 4'h0 : ((k == 0) ? 4'hf : 4'h5)));
		end
		chk({12'h000, irq_enable}, 16'h0005);
		chk({12'h000, timer_zero_mode}, 16'h0005);
		chk({8'h00, timer_zero_load}, 16'h0055);
		chk({13'h0000, display_control}, 16'h0005);
		chk({4'h0, port_data}, 16'h0555);
		chk({4'h0, port_direction}, 16'h0555);
		chk({12'h000, segment_function}, 16'h0005);
		chk({12'h000, edge_and_pull}, 16'h0005);
		chk({12'h000, oscillator_control}, 16'h0001);
		chk({12'h000, display_frame_rate}, 16'h0005);
		chk(rom_table_window, 16'h5555);
		chk({13'h0000, watchdog_control}, 16'h0005);
		chk({12'h000, base_timer_mode, table_branch_nibble}, 16'h0055);
		wr(10'h020, 4'h1);
		wr(10'h0af, 4'h2);
		wr(10'h300, 4'h3);
		wr(10'h313, 4'h4);
		wr(10'h358, 4'h6);
		wr(10'h363, 4'h7);
		wr(10'h0b0, 4'h9);
		wr(10'h314, 4'h9);
		wr(10'h357, 4'h9);
		wr(10'h364, 4'h9);
		rd(10'h020, 4'h1);
		rd(10'h0af, 4'h2);
		rd(10'h300, 4'h3);
		rd(10'h313, 4'h4);
		rd(10'h358, 4'h6);
		rd(10'h363, 4'h7);
		rd(10'h0b0, 4'h0);
		rd(10'h314, 4'h0);
		rd(10'h357, 4'h0);
		rd(10'h364, 4'h0);
		wr(10'h010, 4'h3);
		wr(10'h011, 4'h1);
		wr(10'h012, 4'h6);
		wr(10'h00f, 4'hd);
		rd(10'h313, 4'hd);
		rd(10'h00f, 4'hd);
		wr(10'h012, 4'h0);
		wr(10'h011, 4'h2);
		wr(10'h010, 4'h0);
		rd(10'h00f, 4'h1);
		cpu_halt <= 1'b1;
		wr(10'h020, 4'he);
		stk(1'b1, 1'b0, 13'h1abc);
		chk({12'h000, stack_level}, 16'h0000);
		rd(10'h020, 4'h1);
		cpu_halt <= 1'b0;
		cpu_stop <= 1'b1;
		wr(10'h008, 4'he);
		rd(10'h008, 4'h5);
		cpu_stop <= 1'b0;
		wr(10'h001, 4'h0);
		@(posedge sys_clk);
		mem_wr    <= 1'b1;
		mem_addr  <= 10'h001;
		mem_wdata <= 4'h0;
		irq_set   <= 4'h4;
		@(posedge sys_clk);
		mem_wr  <= 1'b0;
		irq_set <= 4'h0;
		#1;
		chk({12'h000, irq_pending}, 16'h0004);
		@(posedge sys_clk);
		irq_set <= 4'h9;
		@(posedge sys_clk);
		irq_set <= 4'h0;
		rd(10'h001, 4'hd);
		@(posedge sys_clk);
		wdt_overflow <= 1'b1;
		@(posedge sys_clk);
		wdt_overflow <= 1'b0;
		wr(10'h01e, 4'h2);
		rd(10'h01e, 4'ha);
		chk({15'h0000, watchdog_overflow}, 16'h0001);
		for (int i = 1; i <= 9; i++) begin
			stk(1'b1, 1'b0, 13'h0100 + i[12:0]);
			chk({3'h0, stack_top}, {3'h0, 13'h0100 + i[12:0]});
			chk({12'h000, stack_level}, (i > 8) ? 16'h0008 : i[15:0]);
		end
		for (int i = 8; i >= 1; i--) begin
			stk(1'b0, 1'b1, 13'h0000);
			chk({3'h0, stack_top}, (i > 1) ? {3'h0, 13'h0100 + i[12:0]} : 16'h0000);
			chk({12'h000, stack_level}, i[15:0] - 16'h0001);
		end
		summarize();
	end
endmodule : sysreg_bank_tb_top
